// ---- hw/plsr_fifo.v ----
// Word buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; read data registered.

module plsr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter PTR_W = 4
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             in_ready_o,
  output wire             out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i
);

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0]   count_reg;
  reg             out_valid_reg;
  reg [WIDTH-1:0] out_data_reg;

  wire push;
  wire pop;

  // Room left and hand-off conditions
  assign in_ready_o  = (count_reg < DEPTH);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = (count_reg != {(PTR_W+1){1'b0}}) &
                       (~out_valid_reg | out_ready_i);
  assign out_valid_o = out_valid_reg;
  assign out_data_o  = out_data_reg;

  // Pointer wrap at depth
  function [PTR_W-1:0] ptr_inc;
    input [PTR_W-1:0] p;
    begin
      if (p == DEPTH - 1) begin
        ptr_inc = {PTR_W{1'b0}};
      end else begin
        ptr_inc = p + 1'b1;
      end
    end
  endfunction

  // Write port
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers, fill level and registered read data
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg    <= {PTR_W{1'b0}};
      rd_ptr_reg    <= {PTR_W{1'b0}};
      count_reg     <= {(PTR_W+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_reg  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg   <= ptr_inc(rd_ptr_reg);
        out_data_reg <= mem_reg[rd_ptr_reg];
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
      if (pop) begin
        out_valid_reg <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

endmodule

// ---- hw/plsr_top.v ----
// Parallel-load, serial-out eight-stage shift register with dual clocks.
// Assumes all pins synchronous to clk_i; the clock pins are sampled as
// levels and their rising edges detected. Bits shifted out after a load are gathered
// into words and handed out through a small buffer.

`include "plsr_regs.vh"

module plsr_top #(
  parameter WIDTH = `PLSR_WIDTH,
  parameter DEPTH = `PLSR_FIFO_DEPTH,
  parameter PTR_W = `PLSR_FIFO_PTR_W
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             load_n_i,
  input  wire [WIDTH-1:0] parallel_inputs_i,
  input  wire             serial_in_i,
  input  wire             shift_clock_a_i,
  input  wire             shift_clock_b_i,
  output wire             serial_out_true_o,
  output wire             serial_out_comp_o,
  output wire             shift_pulse_o,
  output wire             loading_o,
  output wire [WIDTH-1:0] word_o,
  output wire             word_valid_o,
  input  wire             word_ready_i,
  output wire             capture_ready_o,
  output wire             overflow_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Shift path and pin history
  reg  [WIDTH-1:0]          stages_reg;
  reg  [WIDTH-1:0]          stages_next;
  reg                       clk_a_prev_reg;
  reg                       clk_b_prev_reg;
  reg                       out_true_reg;
  reg                       out_comp_reg;
  reg                       shift_pulse_reg;
  reg                       loading_reg;

  // Word capture and buffer status
  reg  [WIDTH-1:0]          gather_reg;
  reg  [WIDTH-1:0]          gather_next;
  reg  [`PLSR_BITS_W-1:0]   bits_reg;
  reg  [`PLSR_BITS_W-1:0]   bits_next;
  reg                       push_valid_reg;
  reg                       push_valid_next;
  reg  [WIDTH-1:0]          push_data_reg;
  reg  [WIDTH-1:0]          push_data_next;
  reg                       cap_ready_reg;
  reg                       overflow_reg;
  reg                       overflow_next;
  reg  [1:0]                state_reg;
  reg  [1:0]                state_next;

  wire                      rise_a;
  wire                      rise_b;
  wire                      do_shift;
  wire                      do_load;
  wire                      fifo_in_ready;
  wire                      last_bit;

  // ----------------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_LOAD  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------

  // Rising edge on one clock pin while the other pin was low
  function edge_gated;
    input cur;
    input prev;
    input other_prev;
    begin
      edge_gated = cur & ~prev & ~other_prev;
    end
  endfunction

  // Move a word one place up, new bit into the low end
  function [WIDTH-1:0] shift_up;
    input [WIDTH-1:0] value;
    input             low_bit;
    begin
      shift_up = {value[WIDTH-2:0], low_bit};
    end
  endfunction

  // Each pin clocks on its own, the other acts as low-true enable
  assign rise_a = edge_gated(shift_clock_a_i, clk_a_prev_reg,
                             clk_b_prev_reg);
  assign rise_b = edge_gated(shift_clock_b_i, clk_b_prev_reg,
                             clk_a_prev_reg);

  // Load level wins over any edge; a high enable pin blocks the other
  assign do_load  = ~load_n_i;
  assign do_shift = load_n_i & (rise_a | rise_b);

  // Word boundary: eighth shift since the last load or word
  assign last_bit = (bits_reg == WIDTH - 1);

  // ----------------------------------------------------------------------
  // Pin history
  // ----------------------------------------------------------------------

  // Previous pin levels; start high so release never fakes an edge
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_a_prev_reg <= `PLSR_PIN_PREV_RST;
      clk_b_prev_reg <= `PLSR_PIN_PREV_RST;
    end else begin
      clk_a_prev_reg <= shift_clock_a_i;
      clk_b_prev_reg <= shift_clock_b_i;
    end
  end

  // ----------------------------------------------------------------------
  // Stage update
  // ----------------------------------------------------------------------

  // Load copies pins bit for bit, shift moves toward the last stage
  always @* begin
    stages_next = stages_reg;
    if (do_load) begin
      stages_next = parallel_inputs_i;
    end else if (do_shift) begin
      stages_next = shift_up(stages_reg, serial_in_i);
    end
  end

  // Stage flops, fully internal
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      stages_reg <= `PLSR_STAGES_RST;
    end else begin
      stages_reg <= stages_next;
    end
  end

  // ----------------------------------------------------------------------
  // Serial outputs
  // ----------------------------------------------------------------------

  // Last stage and its inverse, updated in step with the stages
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_true_reg <= `PLSR_OUT_TRUE_RST;
      out_comp_reg <= `PLSR_OUT_COMP_RST;
    end else begin
      out_true_reg <= stages_next[WIDTH-1];
      out_comp_reg <= ~stages_next[WIDTH-1];
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------

  // One-cycle echo of each shift or load taken at the last edge
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_pulse_reg <= `PLSR_FLAG_RST;
      loading_reg     <= `PLSR_FLAG_RST;
    end else begin
      shift_pulse_reg <= do_shift;
      loading_reg     <= do_load;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------------

  // Tracks whether the register holds a fresh load or is shifting
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (do_load) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (do_shift) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (do_load) begin
          state_next = ST_LOAD;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State flop; restarts idle so shifts before a load are not gathered
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Word capture
  // ----------------------------------------------------------------------

  // Gather bits leaving the last stage, most significant first
  always @* begin
    gather_next     = gather_reg;
    bits_next       = bits_reg;
    push_valid_next = 1'b0;
    push_data_next  = push_data_reg;
    if (do_load) begin
      bits_next   = `PLSR_BITS_ZERO;
      gather_next = {WIDTH{1'b0}};
    end else if (do_shift && state_reg != ST_IDLE) begin
      gather_next = shift_up(gather_reg, stages_reg[WIDTH-1]);
      if (last_bit) begin
        bits_next       = `PLSR_BITS_ZERO;
        push_valid_next = 1'b1;
        push_data_next  = shift_up(gather_reg, stages_reg[WIDTH-1]);
      end else begin
        bits_next = bits_reg + `PLSR_BITS_ONE;
      end
    end
  end

  // Capture flops
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      gather_reg     <= {WIDTH{1'b0}};
      bits_reg       <= `PLSR_BITS_ZERO;
      push_valid_reg <= `PLSR_FLAG_RST;
      push_data_reg  <= {WIDTH{1'b0}};
    end else begin
      gather_reg     <= gather_next;
      bits_reg       <= bits_next;
      push_valid_reg <= push_valid_next;
      push_data_reg  <= push_data_next;
    end
  end

  // ----------------------------------------------------------------------
  // Overflow and room
  // ----------------------------------------------------------------------

  // Word offered while buffer full is lost; flag sticks until reset
  always @* begin
    overflow_next = overflow_reg;
    if (push_valid_reg && !fifo_in_ready) begin
      overflow_next = 1'b1;
    end
  end

  // Sticky flag and the room seen at the last edge
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      overflow_reg  <= `PLSR_FLAG_RST;
      cap_ready_reg <= `PLSR_FLAG_RST;
    end else begin
      overflow_reg  <= overflow_next;
      cap_ready_reg <= fifo_in_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------------

  // Captured words wait here until the reader takes them
  plsr_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .PTR_W (PTR_W)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid_reg),
    .in_data_i   (push_data_reg),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (word_valid_o),
    .out_data_o  (word_o),
    .out_ready_i (word_ready_i)
  );

  // ----------------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------------

  // Every output taken straight from a flop: serial pair first
  assign serial_out_true_o = out_true_reg;
  assign serial_out_comp_o = out_comp_reg;

  // Status flags
  assign shift_pulse_o     = shift_pulse_reg;
  assign loading_o         = loading_reg;
  assign capture_ready_o   = cap_ready_reg;
  assign overflow_o        = overflow_reg;

endmodule

// ---- shared/plsr_regs.vh ----
// Constants for the parallel-load shift register block.
// Assumes inclusion by bare name from the design files; definitions only.
//
// Functional notes
// - Load low copies all eight parallel inputs into the stages, clocks ignored.
// - While load is low every clock edge is ignored, no shift.
// - Last stage drives true output and its inverse; bit seven leaves first.
// - Each shift puts the serial input value into the first stage.
// - Load high: shift once per rising edge of either clock input.
// - Either clock input shifts on its rising edge while the other is low.
// - A clock input held high as enable freezes all stages.
// - Parallel bit n lands in stage n; stage seven holds bit seven after load.
// - Stages zero to six stay internal, each shift moves values one higher.

`ifndef PLSR_REGS_VH
`define PLSR_REGS_VH

// ----------------------------------------------------------------------
// Shift register geometry
// ----------------------------------------------------------------------
`define PLSR_WIDTH        8
`define PLSR_FIRST_STAGE  0
`define PLSR_BITS_W       4
`define PLSR_BITS_ZERO    4'h0
`define PLSR_BITS_ONE     4'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PLSR_STAGES_RST   8'h00
`define PLSR_PIN_PREV_RST 1'b1
`define PLSR_OUT_TRUE_RST 1'b0
`define PLSR_OUT_COMP_RST 1'b1
`define PLSR_FLAG_RST     1'b0

// ----------------------------------------------------------------------
// Capture buffer
// ----------------------------------------------------------------------
`define PLSR_FIFO_DEPTH   16
`define PLSR_FIFO_PTR_W   4

`endif

// ---- verif/plsr_ctrl.sv ----
// Controller model driving load, shift clock pins and serial data.
// Assumes the system clock; pins change 1 ns after its rising edge.
module plsr_ctrl (
  input  wire logic clk_i,
  output logic      load_n_o,
  output logic [7:0] par_o,
  output logic      ser_o,
  output logic      clk_a_o,
  output logic      clk_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pin = 2'b00;

  assign clk_a_o = pin[0];
  assign clk_b_o = pin[1];
  // Idle pins at time zero
  initial begin
    load_n_o = 1'b1;
    par_o    = 8'h00;
    ser_o    = 1'b0;
  end
  // One edge, then the drive delay
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  // Load p, pins in m rising at the same edge
  task automatic load(input logic [7:0] p, input logic [1:0] m);
    step();
    load_n_o = 1'b0;
    par_o    = p;
    pin      = pin | m;
    step();
    pin      = pin & ~m;
    load_n_o = 1'b1;
  endtask
  // One rising edge on the pins in m, then back low
  task automatic shift(input logic [1:0] m, input logic d);
    step();
    ser_o = d;
    pin   = pin | m;
    step();
    pin   = pin & ~m;
  endtask
  // Second pin as enable, raised only while the first is high
  task automatic hold_b();
    step();
    pin[0] = 1'b1;
    step();
    pin[1] = 1'b1;
    step();
    pin[0] = 1'b0;
  endtask
  // Enable released while the first pin is low
  task automatic free_b();
    step();
    pin[1] = 1'b0;
  endtask
endmodule

// ---- verif/plsr_top_sva.sv ----
// Checker on the shift register top pins.
// Assumes one clock domain with a synchronous active-low reset.
module plsr_top_sva #(
  parameter WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_n_i,
  input  wire logic [WIDTH-1:0] parallel_inputs_i,
  input  wire logic             shift_clock_a_i,
  input  wire logic             shift_clock_b_i,
  input  wire logic             serial_out_true_o,
  input  wire logic             serial_out_comp_o,
  input  wire logic             shift_pulse_o,
  input  wire logic             loading_o,
  input  wire logic             word_valid_o,
  input  wire logic             word_ready_i
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  load_copy_a: assert property (!load_n_i |=>
    serial_out_true_o == $past(parallel_inputs_i[WIDTH-1]))
    else $error("top bit not loaded");
  comp_inverse_a: assert property (serial_out_comp_o == !serial_out_true_o)
    else $error("outputs not complementary");
  load_flag_a: assert property (!load_n_i |=> loading_o && !shift_pulse_o)
    else $error("shift during load");
  shift_a_edge_a: assert property (load_n_i && shift_clock_a_i
    && !$past(shift_clock_a_i) && !$past(shift_clock_b_i) && $past(rst_n_i) |=> shift_pulse_o)
    else $error("first pin edge lost");
  shift_b_edge_a: assert property (load_n_i && shift_clock_b_i
    && !$past(shift_clock_b_i) && !$past(shift_clock_a_i) && $past(rst_n_i) |=> shift_pulse_o)
    else $error("second pin edge lost");
  enable_hold_a: assert property ($past(shift_clock_b_i) |=> !shift_pulse_o)
    else $error("shift while disabled");
  single_shift_a: assert property (shift_pulse_o |=> !shift_pulse_o)
    else $error("double shift");
  quiet_hold_a: assert property (!shift_pulse_o && !loading_o && $past(rst_n_i)
    |-> $stable(serial_out_true_o))
    else $error("output moved without shift");

  // Main scenarios
  cover property (!load_n_i ##1 load_n_i);
  cover property (shift_pulse_o ##2 shift_pulse_o);
  cover property (word_valid_o && word_ready_i);
endmodule

bind plsr_top plsr_top_sva #(.WIDTH(WIDTH)) sva_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .load_n_i(load_n_i),
  .parallel_inputs_i(parallel_inputs_i), .shift_clock_a_i(shift_clock_a_i),
  .shift_clock_b_i(shift_clock_b_i), .serial_out_true_o(serial_out_true_o),
  .serial_out_comp_o(serial_out_comp_o), .shift_pulse_o(shift_pulse_o),
  .loading_o(loading_o), .word_valid_o(word_valid_o), .word_ready_i(word_ready_i)
);

// ---- verif/testbench.sv ----
// Self-checking bench for the shift register top and its word buffer.
// Assumes the controller model and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] p;
    logic [7:0] s;
    logic [1:0] m;
    logic [7:0] w0;
    logic [7:0] w1;
  } plsr_row_t;
  logic        clk, rst_n, load_n, ser, ca, cb, out_t, out_c, pulse, loading;
  logic        word_valid, word_ready, cap_ready, overflow;
  logic [7:0]  par, word;
  logic [15:0] v;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  plsr_row_t   rows [4];

  plsr_ctrl ctrl_u (.clk_i(clk), .load_n_o(load_n), .par_o(par), .ser_o(ser),
    .clk_a_o(ca), .clk_b_o(cb));
  plsr_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .load_n_i(load_n),
    .parallel_inputs_i(par), .serial_in_i(ser), .shift_clock_a_i(ca),
    .shift_clock_b_i(cb), .serial_out_true_o(out_t), .serial_out_comp_o(out_c),
    .shift_pulse_o(pulse), .loading_o(loading), .word_o(word),
    .word_valid_o(word_valid), .word_ready_i(word_ready),
    .capture_ready_o(cap_ready), .overflow_o(overflow));

  // Clock and hang limit
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Wait for a buffered word, compare it, take it
  task automatic read_word(input logic [7:0] exp);
    int i;
    @(posedge clk);
    #1;
    for (i = 0; i < 40 && word_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(word_valid, 1'b1);
    check(word, exp);
    word_ready = 1'b1;
    @(posedge clk);
    #1;
    word_ready = 1'b0;
  endtask
  // Main sequence
  initial begin
    rst_n      = 1'b0;
    word_ready = 1'b0;
    rows[0] = '{8'ha5, 8'h3c, 2'b01, 8'ha5, 8'h3c};
    rows[1] = '{8'h01, 8'h80, 2'b10, 8'h01, 8'h80};
    rows[2] = '{8'hff, 8'h00, 2'b11, 8'hff, 8'h00};
    rows[3] = '{8'h5a, 8'hc3, 2'b10, 8'h5a, 8'hc3};
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check({out_c, out_t, word_valid, overflow}, 4'h8);
    repeat (8) ctrl_u.shift(2'b01, 1'b1);
    repeat (3) ctrl_u.step();
    check({word_valid, out_t}, 2'h1);
    $display("test reset done");
    foreach (rows[r]) begin
      v = {rows[r].p, rows[r].s};
      ctrl_u.load(rows[r].p, 2'b00);
      for (int k = 0; k < 16; k++) begin
        check({out_c, out_t}, {~v[15-k], v[15-k]});
        ctrl_u.shift(rows[r].m, rows[r].s[(15-k)%8]);
      end
      read_word(rows[r].w0);
      read_word(rows[r].w1);
    end
    $display("test rows done");
    ctrl_u.load(8'h00, 2'b11);
    ctrl_u.step();
    ctrl_u.step();
    check({out_c, out_t}, 2'b10);
    $display("test load priority done");
    ctrl_u.load(8'hb4, 2'b00);
    ctrl_u.hold_b();
    check(out_t, 1'b0);
    repeat (3) ctrl_u.shift(2'b01, 1'b1);
    check(out_t, 1'b0);
    ctrl_u.free_b();
    ctrl_u.shift(2'b01, 1'b1);
    check(out_t, 1'b1);
    $display("test enable done");
    for (int i = 0; i < 18; i++) begin
      ctrl_u.load(8'h10 + i[7:0], 2'b00);
      repeat (8) ctrl_u.shift(2'b01, 1'b0);
    end
    repeat (3) ctrl_u.step();
    check({overflow, cap_ready}, 2'b10);
    for (int i = 0; i < 17; i++) read_word(8'h10 + i[7:0]);
    repeat (3) ctrl_u.step();
    check(word_valid, 1'b0);
    $display("test buffer done");
    wrap_up();
  end
endmodule
